// File: shared/dbg_status_pkg.sv
// register numbers, field layouts and encodings of the processor status bank
package dbg_status_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  localparam logic [7:0] REG_BOOT_STATUS   = 8'h03;
  localparam logic [7:0] REG_OSC_A         = 8'h07;
  localparam logic [7:0] REG_OSC_TILE_WIRE = 8'h08;
  localparam logic [7:0] REG_OSC_CELL      = 8'h09;
  localparam logic [7:0] REG_OSC_WIRE      = 8'h0A;
  localparam logic [7:0] REG_MEM_SIZE      = 8'h0C;
  localparam logic [7:0] REG_SAVED_SP      = 8'h12;
  localparam logic [7:0] REG_FETCH_THREAD  = 8'h13;
  localparam logic [7:0] REG_FETCH_REG     = 8'h14;
  localparam logic [7:0] REG_CAUSE         = 8'h15;
  localparam logic [7:0] REG_IBRK_ADDR     = 8'h30;
  localparam logic [7:0] REG_IBRK_CTRL     = 8'h40;
  localparam logic [7:0] REG_WATCH_FIRST   = 8'h50;
  localparam logic [7:0] REG_WATCH_SECOND  = 8'h60;
  // each group of four: base plus index in bits 1:0
  localparam logic [7:0] GROUP_MASK        = 8'hFC;

  localparam int unsigned NUM_POINTS = 4;
  localparam int unsigned PT_W       = 2;
  localparam int unsigned NUM_THREADS = 8;
  localparam int unsigned THREAD_W   = 8;
  localparam int unsigned OSC_W      = 16;

  // boot status fields
  localparam int unsigned BS_PROC_LSB   = 16;
  localparam int unsigned BS_OVERWRITE  = 8;
  localparam int unsigned BS_CORE1_OFF  = 5;
  localparam int unsigned BS_SKIP_OTP   = 4;
  localparam int unsigned BS_FROM_RAM   = 3;
  localparam int unsigned BS_FROM_JTAG  = 2;
  localparam int unsigned BS_PLL_LSB    = 0;

  // cause record fields
  localparam int unsigned CR_POINT_LSB  = 16;
  localparam int unsigned CR_THREAD_LSB = 8;
  localparam int unsigned CR_CAUSE_LSB  = 0;
  localparam int unsigned CAUSE_W       = 3;
  localparam int unsigned FETCH_REG_W   = 5;

  // breakpoint control fields
  localparam int unsigned BC_THREAD_LSB = 16;
  localparam int unsigned BC_NOT_EQUAL  = 1;
  localparam int unsigned BC_ENABLE     = 0;

  typedef enum logic [2:0] {
    CAUSE_NONE     = 3'h0,
    CAUSE_HOST     = 3'h1,
    CAUSE_CALL     = 3'h2,
    CAUSE_IBREAK   = 3'h3,
    CAUSE_DWATCH   = 3'h4,
    CAUSE_RWATCH   = 3'h5
  } cause_t;

  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [15:0] OSC_ONE   = 16'h0001;
endpackage : dbg_status_pkg

// File: src/osc_counter.sv
// free-running ring oscillator count sampled into the tile clock
`timescale 1ns/10ps
`default_nettype none
module osc_counter #(
  parameter int unsigned WIDTH = 16
) (
  input  wire logic             sys_clk,
  input  wire logic             osc_tick,
  output var  logic [WIDTH-1:0] count_q
);
  typedef struct packed {
    logic [WIDTH-1:0] count;
  } osc_state_t;

  osc_state_t state_q = '0;  // power-on value only, srst never clears it
  osc_state_t state_d;

  // no reset at all: the count survives a system reset
  always_comb begin
    state_d = state_q;
    if (osc_tick) begin
      state_d.count = state_q.count + WIDTH'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    state_q <= state_d;
  end

  assign count_q = state_q.count;
endmodule : osc_counter
`default_nettype wire

// File: src/debug_status_register_bank.sv
// processor status register bank with boot status and debug support state
// Operation
// - boot status is read-only; bits 23:16 give the tile processor number
// - boot status bits 1:0 give the sampled boot PLL mode pins
// - boot status bit 3 boots from RAM, bit 2 boots through JTAG
// - boot status bit 5 reads set when the second core is off
// - boot status bit 4 tells boot code to skip OTP level polling
// - four counters show A, tile-wire, cell, wire oscillator counts, bits 15:0
// - oscillator counts are not cleared by system reset
// - RAM size register returns tile RAM size in bytes
// - fetch operand one holds logical core number in bits 7:0
// - fetch operand two holds register number in bits 4:0
// - cause field bits 2:0 encode host, call, break, data, resource
// - bits 17:16 hold firing point number, zero for host and call
// - simultaneous triggers record the lowest-numbered point
// - bits 15:8 hold the causing thread, zero for host request
// - four 32-bit breakpoint address registers hold compare PC values
// - breakpoint control bits 23:16 enable the breakpoint per thread
// - control bit 1 selects fire on equal (0) or unequal (1)
// - control bit 0 enables the breakpoint; control fields reset to zero
// - four registers hold each data watchpoint's first address
// - four registers hold each data watchpoint's second address
`timescale 1ns/10ps
`default_nettype none
module debug_status_register_bank #(
  parameter logic [31:0] MEM_SIZE_BYTES = 32'h0002_0000,
  parameter logic [7:0]  PROC_NUMBER    = 8'h00
) (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // processor status access
  input  wire logic        ps_read,
  input  wire logic        ps_write,
  input  wire logic [7:0]  ps_reg,
  input  wire logic [31:0] ps_wdata,
  output var  logic [31:0] ps_rdata,
  output var  logic        ps_ack,
  output var  logic        ps_err,
  // boot straps and status
  input  wire logic [1:0]  pll_mode_pins,
  input  wire logic        boot_from_ram,
  input  wire logic        boot_from_jtag,
  input  wire logic        skip_otp_poll,
  input  wire logic        core1_powered_off,
  input  wire logic        boot_mode_overwrite,
  // ring oscillator ticks, one per oscillator
  input  wire logic [3:0]  osc_tick,
  // debug events from the processor
  input  wire logic        host_debug_req,
  input  wire logic        debug_call_instr,
  input  wire logic        data_watch_hit,
  input  wire logic        resource_watch_hit,
  input  wire logic [3:0]  watch_hit_points,
  input  wire logic [7:0]  event_thread,
  input  wire logic [31:0] thread_pc,
  input  wire logic        pc_valid,
  // breakpoint match and recorded debug entry
  output var  logic [3:0]  instr_break_hit,
  output var  logic        debug_entry,
  output var  logic [7:0]  debug_register_fetch_thread,
  output var  logic [4:0]  debug_register_fetch_reg
);
  localparam int unsigned NP = dbg_status_pkg::NUM_POINTS;

  typedef struct packed {
    logic [31:0]            rdata;
    logic                   ack;
    logic                   err;
    logic [31:0]            boot_status;
    logic                   boot_caught;
    logic [31:0]            saved_sp;
    logic [7:0]             fetch_thread;
    logic [4:0]             fetch_reg;
    logic [2:0]             cause;
    logic [7:0]             cause_thread;
    logic [1:0]             cause_point;
    logic [NP-1:0][31:0]    ibrk_addr;
    logic [NP-1:0][7:0]     ibrk_threads;
    logic [NP-1:0]          ibrk_ne;
    logic [NP-1:0]          ibrk_en;
    logic [NP-1:0][31:0]    watch_first;
    logic [NP-1:0][31:0]    watch_second;
    logic [NP-1:0]          brk_hit;
    logic                   entry;
  } bank_state_t;

  bank_state_t state_q;
  bank_state_t state_d;

  logic [3:0][15:0] osc_count;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_osc
      osc_counter #(
        .WIDTH (dbg_status_pkg::OSC_W)
      ) u_osc (
        .sys_clk  (sys_clk),
        .osc_tick (osc_tick[gi]),
        .count_q  (osc_count[gi])
      );
    end
  endgenerate

  // breakpoint compare on the current pc for the issuing thread
  function automatic logic bp_match(
    input logic        en,
    input logic        ne,
    input logic [7:0]  threads,
    input logic [31:0] addr,
    input logic [31:0] pc,
    input logic [7:0]  thr
  );
    logic eq;
    logic thr_ok;
    eq     = (pc == addr);
    thr_ok = (thr < 8'(dbg_status_pkg::NUM_THREADS)) && threads[thr[2:0]];
    return en && thr_ok && (ne ? !eq : eq);
  endfunction : bp_match

  logic [NP-1:0] hit_now;
  logic [1:0]    low_ibrk;
  logic [1:0]    low_watch;
  logic [1:0]    idx;
  logic [7:0]    grp;

  always_comb begin
    hit_now   = '0;
    low_ibrk  = '0;
    low_watch = '0;
    for (int i = 0; i < NP; i++) begin
      hit_now[i] = pc_valid && bp_match(state_q.ibrk_en[i],
                                        state_q.ibrk_ne[i],
                                        state_q.ibrk_threads[i],
                                        state_q.ibrk_addr[i],
                                        thread_pc, event_thread);
    end
    // scan downward so the lowest number wins
    for (int i = NP - 1; i >= 0; i--) begin
      if (hit_now[i]) begin
        low_ibrk = 2'(i);
      end
      if (watch_hit_points[i]) begin
        low_watch = 2'(i);
      end
    end
  end

  always_comb begin
    state_d     = state_q;
    state_d.ack = 1'b0;
    state_d.err = 1'b0;
    state_d.entry = 1'b0;
    state_d.brk_hit = hit_now;
    idx = ps_reg[1:0];
    grp = ps_reg & dbg_status_pkg::GROUP_MASK;

    // straps are caught by a clocked process after reset release
    if (!state_q.boot_caught) begin
      state_d.boot_caught = 1'b1;
      state_d.boot_status = dbg_status_pkg::ZERO_WORD;
      state_d.boot_status[dbg_status_pkg::BS_PROC_LSB +: 8] = PROC_NUMBER;
      state_d.boot_status[dbg_status_pkg::BS_PLL_LSB +: 2] = pll_mode_pins;
      state_d.boot_status[dbg_status_pkg::BS_FROM_RAM]  = boot_from_ram;
      state_d.boot_status[dbg_status_pkg::BS_FROM_JTAG] = boot_from_jtag;
      state_d.boot_status[dbg_status_pkg::BS_CORE1_OFF] = core1_powered_off;
      state_d.boot_status[dbg_status_pkg::BS_SKIP_OTP]  = skip_otp_poll;
      state_d.boot_status[dbg_status_pkg::BS_OVERWRITE] = boot_mode_overwrite;
    end
    state_d.boot_status[dbg_status_pkg::BS_CORE1_OFF] = core1_powered_off;

    // writes; read-only and unmapped registers flag an error
    if (ps_write) begin
      state_d.ack = 1'b1;
      if (ps_reg == dbg_status_pkg::REG_SAVED_SP) begin
        state_d.saved_sp = ps_wdata;
      end else if (ps_reg == dbg_status_pkg::REG_FETCH_THREAD) begin
        state_d.fetch_thread = ps_wdata[7:0];
      end else if (ps_reg == dbg_status_pkg::REG_FETCH_REG) begin
        state_d.fetch_reg = ps_wdata[4:0];
      end else if (ps_reg == dbg_status_pkg::REG_CAUSE) begin
        state_d.cause        = ps_wdata[dbg_status_pkg::CR_CAUSE_LSB +: 3];
        state_d.cause_thread = ps_wdata[dbg_status_pkg::CR_THREAD_LSB +: 8];
        state_d.cause_point  = ps_wdata[dbg_status_pkg::CR_POINT_LSB +: 2];
      end else if (grp == dbg_status_pkg::REG_IBRK_ADDR) begin
        state_d.ibrk_addr[idx] = ps_wdata;
      end else if (grp == dbg_status_pkg::REG_IBRK_CTRL) begin
        state_d.ibrk_threads[idx] =
          ps_wdata[dbg_status_pkg::BC_THREAD_LSB +: 8];
        state_d.ibrk_ne[idx] = ps_wdata[dbg_status_pkg::BC_NOT_EQUAL];
        state_d.ibrk_en[idx] = ps_wdata[dbg_status_pkg::BC_ENABLE];
      end else if (grp == dbg_status_pkg::REG_WATCH_FIRST) begin
        state_d.watch_first[idx] = ps_wdata;
      end else if (grp == dbg_status_pkg::REG_WATCH_SECOND) begin
        state_d.watch_second[idx] = ps_wdata;
      end else begin
        state_d.err = 1'b1;
      end
    end else if (ps_read) begin
      state_d.ack   = 1'b1;
      state_d.rdata = dbg_status_pkg::ZERO_WORD;
      if (ps_reg == dbg_status_pkg::REG_BOOT_STATUS) begin
        state_d.rdata = state_q.boot_status;
      end else if (ps_reg == dbg_status_pkg::REG_OSC_A) begin
        state_d.rdata[15:0] = osc_count[0];
      end else if (ps_reg == dbg_status_pkg::REG_OSC_TILE_WIRE) begin
        state_d.rdata[15:0] = osc_count[1];
      end else if (ps_reg == dbg_status_pkg::REG_OSC_CELL) begin
        state_d.rdata[15:0] = osc_count[2];
      end else if (ps_reg == dbg_status_pkg::REG_OSC_WIRE) begin
        state_d.rdata[15:0] = osc_count[3];
      end else if (ps_reg == dbg_status_pkg::REG_MEM_SIZE) begin
        state_d.rdata = MEM_SIZE_BYTES;
      end else if (ps_reg == dbg_status_pkg::REG_SAVED_SP) begin
        state_d.rdata = state_q.saved_sp;
      end else if (ps_reg == dbg_status_pkg::REG_FETCH_THREAD) begin
        state_d.rdata[7:0] = state_q.fetch_thread;
      end else if (ps_reg == dbg_status_pkg::REG_FETCH_REG) begin
        state_d.rdata[4:0] = state_q.fetch_reg;
      end else if (ps_reg == dbg_status_pkg::REG_CAUSE) begin
        state_d.rdata[dbg_status_pkg::CR_CAUSE_LSB +: 3]  = state_q.cause;
        state_d.rdata[dbg_status_pkg::CR_THREAD_LSB +: 8] = state_q.cause_thread;
        state_d.rdata[dbg_status_pkg::CR_POINT_LSB +: 2]  = state_q.cause_point;
      end else if (grp == dbg_status_pkg::REG_IBRK_ADDR) begin
        state_d.rdata = state_q.ibrk_addr[idx];
      end else if (grp == dbg_status_pkg::REG_IBRK_CTRL) begin
        state_d.rdata[dbg_status_pkg::BC_THREAD_LSB +: 8] =
          state_q.ibrk_threads[idx];
        state_d.rdata[dbg_status_pkg::BC_NOT_EQUAL] = state_q.ibrk_ne[idx];
        state_d.rdata[dbg_status_pkg::BC_ENABLE]    = state_q.ibrk_en[idx];
      end else if (grp == dbg_status_pkg::REG_WATCH_FIRST) begin
        state_d.rdata = state_q.watch_first[idx];
      end else if (grp == dbg_status_pkg::REG_WATCH_SECOND) begin
        state_d.rdata = state_q.watch_second[idx];
      end else begin
        state_d.err = 1'b1;
      end
    end

    // debug entry beats a same-cycle software write to the record;
    // host request takes priority, then call, then break, data, resource
    if (host_debug_req) begin
      state_d.entry        = 1'b1;
      state_d.cause        = dbg_status_pkg::CAUSE_HOST;
      state_d.cause_thread = '0;
      state_d.cause_point  = '0;
    end else if (debug_call_instr) begin
      state_d.entry        = 1'b1;
      state_d.cause        = dbg_status_pkg::CAUSE_CALL;
      state_d.cause_thread = event_thread;
      state_d.cause_point  = '0;
    end else if (|hit_now) begin
      state_d.entry        = 1'b1;
      state_d.cause        = dbg_status_pkg::CAUSE_IBREAK;
      state_d.cause_thread = event_thread;
      state_d.cause_point  = low_ibrk;
    end else if (data_watch_hit) begin
      state_d.entry        = 1'b1;
      state_d.cause        = dbg_status_pkg::CAUSE_DWATCH;
      state_d.cause_thread = event_thread;
      state_d.cause_point  = low_watch;
    end else if (resource_watch_hit) begin
      state_d.entry        = 1'b1;
      state_d.cause        = dbg_status_pkg::CAUSE_RWATCH;
      state_d.cause_thread = event_thread;
      state_d.cause_point  = low_watch;
    end

    if (srst) begin
      state_d.rdata        = dbg_status_pkg::ZERO_WORD;
      state_d.ack          = 1'b0;
      state_d.err          = 1'b0;
      state_d.boot_caught  = 1'b0;
      state_d.boot_status  = dbg_status_pkg::ZERO_WORD;
      state_d.cause        = dbg_status_pkg::CAUSE_NONE;
      state_d.cause_thread = '0;
      state_d.cause_point  = '0;
      state_d.fetch_thread = '0;
      state_d.fetch_reg    = '0;
      state_d.saved_sp     = dbg_status_pkg::ZERO_WORD;
      state_d.ibrk_threads = '0;
      state_d.ibrk_ne      = '0;
      state_d.ibrk_en      = '0;
      state_d.ibrk_addr    = '0;
      state_d.watch_first  = '0;
      state_d.watch_second = '0;
      state_d.brk_hit      = '0;
      state_d.entry        = 1'b0;
    end
  end

  // one register write of the whole record keeps fields consistent
  always_ff @(posedge sys_clk) begin
    state_q <= state_d;
  end

  assign ps_rdata        = state_q.rdata;
  assign ps_ack          = state_q.ack;
  assign ps_err          = state_q.err;
  assign instr_break_hit = state_q.brk_hit;
  assign debug_entry     = state_q.entry;
  assign debug_register_fetch_thread = state_q.fetch_thread;
  assign debug_register_fetch_reg    = state_q.fetch_reg;
endmodule : debug_status_register_bank
`default_nettype wire

// File: dv/dbg_status_checker_asserts.sv
// port-level checker for the processor status bank, bound at the foot
`timescale 1ns/10ps
`default_nettype none
module dbg_status_checker #(
  parameter logic [31:0] MEM_SIZE_BYTES = 32'h0002_0000,
  parameter logic [7:0]  PROC_NUMBER    = 8'h00
) (
  input wire logic        sys_clk,
  input wire logic        srst,
  input wire logic        ps_read,
  input wire logic        ps_write,
  input wire logic [7:0]  ps_reg,
  input wire logic [31:0] ps_wdata,
  input wire logic [31:0] ps_rdata,
  input wire logic        ps_ack,
  input wire logic        ps_err,
  input wire logic        host_debug_req,
  input wire logic [7:0]  event_thread,
  input wire logic [31:0] thread_pc,
  input wire logic        pc_valid,
  input wire logic [3:0]  instr_break_hit,
  input wire logic        debug_entry,
  input wire logic [7:0]  debug_register_fetch_thread,
  input wire logic [4:0]  debug_register_fetch_reg
);
  logic [31:0] ctrl0_q;
  logic [31:0] addr0_q;
  logic        bp_exp;

  // shadow of breakpoint 0 so its match can be predicted from the ports
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl0_q <= 32'h0000_0000;
      addr0_q <= 32'h0000_0000;
    end else if (ps_write && ps_reg == dbg_status_pkg::REG_IBRK_CTRL) begin
      ctrl0_q <= ps_wdata;
    end else if (ps_write && ps_reg == dbg_status_pkg::REG_IBRK_ADDR) begin
      addr0_q <= ps_wdata;
    end
  end

  assign bp_exp = ctrl0_q[0] && event_thread[7:3] == 5'h00
                  && ctrl0_q[{2'b10, event_thread[2:0]}]
                  && (ctrl0_q[1] ? thread_pc != addr0_q : thread_pc == addr0_q);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence s_req; ps_read || ps_write; endsequence
  sequence s_wr(logic [7:0] r); ps_write && ps_reg == r; endsequence
  // boot status is valid only from the second edge after release
  sequence s_rd(logic [7:0] r);
    ps_read && !ps_write && ps_reg == r && !$past(srst);
  endsequence

  property p_ack_follows; s_req |=> ps_ack; endproperty
  property p_ack_cause; ps_ack |-> $past(ps_read || ps_write); endproperty
  property p_err_with_ack; ps_err |-> ps_ack; endproperty
  property p_boot_ro; s_wr(dbg_status_pkg::REG_BOOT_STATUS) |=> ps_err;
  endproperty
  property p_proc_num;
    s_rd(dbg_status_pkg::REG_BOOT_STATUS) |=> ps_rdata[23:16] == PROC_NUMBER;
  endproperty
  property p_mem_size;
    s_rd(dbg_status_pkg::REG_MEM_SIZE) |=> ps_rdata == MEM_SIZE_BYTES;
  endproperty
  property p_fetch_thr;
    s_wr(dbg_status_pkg::REG_FETCH_THREAD) |=>
      {24'h00_0000, debug_register_fetch_thread}
        == ($past(ps_wdata) & 32'h0000_00FF);
  endproperty
  property p_fetch_reg;
    s_wr(dbg_status_pkg::REG_FETCH_REG) |=>
      {27'h000_0000, debug_register_fetch_reg}
        == ($past(ps_wdata) & 32'h0000_001F);
  endproperty
  property p_bp_match;
    pc_valid && !ps_write |=> instr_break_hit[0] == $past(bp_exp);
  endproperty
  property p_host_entry; host_debug_req |=> debug_entry; endproperty

  a_ack_follows: assert property (p_ack_follows)
    else $error("no ack one cycle after a request");
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without a request");
  a_err_with_ack: assert property (p_err_with_ack)
    else $error("error pulse without ack");
  a_boot_ro: assert property (p_boot_ro)
    else $error("write to boot status not refused");
  a_proc_num: assert property (p_proc_num)
    else $error("boot status processor number wrong");
  a_mem_size: assert property (p_mem_size)
    else $error("memory size read wrong");
  a_fetch_thr: assert property (p_fetch_thr)
    else $error("fetch thread copy wrong");
  a_fetch_reg: assert property (p_fetch_reg)
    else $error("fetch register copy wrong");
  a_bp_match: assert property (p_bp_match)
    else $error("breakpoint 0 match wrong");
  a_host_entry: assert property (p_host_entry)
    else $error("host request did not enter debug");
endmodule : dbg_status_checker

bind debug_status_register_bank dbg_status_checker #(
  .MEM_SIZE_BYTES(MEM_SIZE_BYTES), .PROC_NUMBER(PROC_NUMBER)
) dbg_status_checker_inst (
  .sys_clk(sys_clk), .srst(srst), .ps_read(ps_read), .ps_write(ps_write),
  .ps_reg(ps_reg), .ps_wdata(ps_wdata), .ps_rdata(ps_rdata),
  .ps_ack(ps_ack), .ps_err(ps_err), .host_debug_req(host_debug_req),
  .event_thread(event_thread), .thread_pc(thread_pc), .pc_valid(pc_valid),
  .instr_break_hit(instr_break_hit), .debug_entry(debug_entry),
  .debug_register_fetch_thread(debug_register_fetch_thread),
  .debug_register_fetch_reg(debug_register_fetch_reg)
);
`default_nettype wire

// File: dv/tile_osc_model.sv
// ring oscillator stand-in: tick pulses at four distinct rates, counted
`timescale 1ns/10ps
`default_nettype none
module tile_osc_model (
  input  wire logic        sys_clk,
  input  wire logic        run,
  output var  logic [3:0]  osc_tick,
  output var  logic [15:0] n_ticks [4]
);
  logic [2:0] div_q [4];

  initial begin
    osc_tick = 4'h0;
    for (int i = 0; i < 4; i++) begin
      div_q[i] = 3'h0;
      n_ticks[i] = 16'h0000;
    end
  end

  // distinct rates make a swapped counter address show up as a wrong count
  always @(posedge sys_clk) begin
    for (int i = 0; i < 4; i++) begin
      osc_tick[i] <= run && div_q[i] == 3'(i + 1);
      if (run && div_q[i] == 3'(i + 1)) begin
        div_q[i] <= 3'h0;
        n_ticks[i] <= n_ticks[i] + 16'h0001;
      end else if (run) begin
        div_q[i] <= div_q[i] + 3'h1;
      end
    end
  end
endmodule : tile_osc_model
`default_nettype wire

// File: dv/test_debug_status_register_bank.sv
// directed testbench for the processor status register bank
`timescale 1ns/10ps
`default_nettype none
module test_debug_status_register_bank;
  localparam logic [7:0]  PROC  = 8'h5A;
  localparam logic [31:0] MEMSZ = 32'h0002_0000;
  logic        sys_clk = 1'b0;
  logic        srst = 1'b1;
  logic        ps_read = 1'b0;
  logic        ps_write = 1'b0;
  logic [7:0]  ps_reg = 8'h00;
  logic [31:0] ps_wdata = 32'h0000_0000;
  logic [1:0]  pll_mode_pins = 2'h2;
  logic        core1_off = 1'b1;
  logic [3:0]  strap = 4'hD;
  logic [4:0]  ev_q = 5'h00;
  logic [3:0]  watch_hit_points = 4'h0;
  logic [7:0]  event_thread = 8'h00;
  logic [31:0] thread_pc = 32'h0000_0000;
  logic        osc_run = 1'b0;
  logic [31:0] ps_rdata;
  logic        ps_ack;
  logic        ps_err;
  logic [3:0]  osc_tick;
  logic [3:0]  instr_break_hit;
  logic        debug_entry;
  logic [7:0]  fthr;
  logic [4:0]  freg;
  logic [15:0] n_ticks [4];
  logic [15:0] m1 [4];
  logic [31:0] v1 [4];
  logic [31:0] rd_q;
  int          n_fail = 0;
  int          num_checks = 0;

  debug_status_register_bank #(.MEM_SIZE_BYTES(MEMSZ), .PROC_NUMBER(PROC))
  debug_status_register_bank_inst (
    .sys_clk(sys_clk), .srst(srst), .ps_read(ps_read), .ps_write(ps_write),
    .ps_reg(ps_reg), .ps_wdata(ps_wdata), .ps_rdata(ps_rdata),
    .ps_ack(ps_ack), .ps_err(ps_err), .pll_mode_pins(pll_mode_pins),
    .boot_from_ram(strap[0]), .boot_from_jtag(strap[1]),
    .skip_otp_poll(strap[2]), .core1_powered_off(core1_off),
    .boot_mode_overwrite(strap[3]),
    .osc_tick(osc_tick), .host_debug_req(ev_q[0]),
    .debug_call_instr(ev_q[1]), .data_watch_hit(ev_q[2]),
    .resource_watch_hit(ev_q[3]), .watch_hit_points(watch_hit_points),
    .event_thread(event_thread), .thread_pc(thread_pc), .pc_valid(ev_q[4]),
    .instr_break_hit(instr_break_hit), .debug_entry(debug_entry),
    .debug_register_fetch_thread(fthr), .debug_register_fetch_reg(freg));

  tile_osc_model tile_osc_model_inst (
    .sys_clk(sys_clk), .run(osc_run), .osc_tick(osc_tick), .n_ticks(n_ticks));

  initial begin
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // one-cycle request pulse; the answer lands on the edge that takes it
  task automatic access(input logic wr, input logic [7:0] r,
                        input logic [31:0] d, input logic err);
    @(posedge sys_clk);
    ps_write <= wr;
    ps_read <= !wr;
    ps_reg <= r;
    ps_wdata <= d;
    @(posedge sys_clk);
    ps_write <= 1'b0;
    ps_read <= 1'b0;
    #1;
    check({30'h0, ps_ack, ps_err}, {30'h0, 1'b1, err});
    rd_q = ps_rdata;
  endtask : access

  task automatic rd(input logic [7:0] r, input logic [31:0] exp, input logic err);
    access(1'b0, r, 32'h0000_0000, err);
    check(rd_q, exp);
  endtask : rd

  task automatic ev(input logic [4:0] k, input logic [7:0] thr,
                    input logic [3:0] pts, input logic [31:0] pc,
                    input logic [3:0] hit, input logic ent,
                    input logic [31:0] cause);
    @(posedge sys_clk);
    ev_q <= k;
    event_thread <= thr;
    watch_hit_points <= pts;
    thread_pc <= pc;
    @(posedge sys_clk);
    ev_q <= 5'h00;
    #1;
    check({27'h0, instr_break_hit, debug_entry}, {27'h0, hit, ent});
    rd(dbg_status_pkg::REG_CAUSE, cause, 1'b0);
  endtask : ev

  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report

  initial begin
    repeat (5000) @(posedge sys_clk);
    n_fail++;
    final_report();
  end

  initial begin
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rd(dbg_status_pkg::REG_IBRK_CTRL, 32'h0000_0000, 1'b0);
    rd(dbg_status_pkg::REG_CAUSE, 32'h0000_0000, 1'b0);
    rd(8'h03, {8'h00, PROC, 16'h013A}, 1'b0);
    core1_off <= 1'b0;
    access(1'b1, 8'h03, 32'hFFFF_FFFF, 1'b1);
    rd(8'h03, {8'h00, PROC, 16'h011A}, 1'b0);
    rd(dbg_status_pkg::REG_MEM_SIZE, MEMSZ, 1'b0);
    rd(8'h01, 32'h0000_0000, 1'b1);
    access(1'b1, dbg_status_pkg::REG_OSC_CELL, 32'h0000_0001, 1'b1);
    $display("test boot status done");
    access(1'b1, 8'h13, 32'hFFFF_FFA5, 1'b0);
    rd(8'h13, 32'h0000_00A5, 1'b0);
    access(1'b1, 8'h14, 32'hFFFF_FFF3, 1'b0);
    rd(8'h14, 32'h0000_0013, 1'b0);
    check({19'h0, freg, fthr}, 32'h0000_13A5);
    access(1'b1, 8'h12, 32'h5A5A_0012, 1'b0);
    rd(8'h12, 32'h5A5A_0012, 1'b0);
    for (int i = 0; i < 4; i++) begin
      access(1'b1, 8'h30 + 8'(i), 32'h1000_0000 + i, 1'b0);
      access(1'b1, 8'h50 + 8'(i), 32'h2000_0000 + i, 1'b0);
      access(1'b1, 8'h60 + 8'(i), 32'h3000_0000 + i, 1'b0);
    end
    for (int i = 0; i < 4; i++) begin
      rd(8'h30 + 8'(i), 32'h1000_0000 + i, 1'b0);
      rd(8'h50 + 8'(i), 32'h2000_0000 + i, 1'b0);
      rd(8'h60 + 8'(i), 32'h3000_0000 + i, 1'b0);
    end
    $display("test operand and address registers done");
    access(1'b1, 8'h40, 32'h0004_0001, 1'b0);
    ev(5'h10, 8'h02, 4'h0, 32'h1000_0000, 4'h1, 1'b1, 32'h0000_0203);
    ev(5'h10, 8'h01, 4'h0, 32'h1000_0000, 4'h0, 1'b0, 32'h0000_0203);
    access(1'b1, 8'h40, 32'h0004_0003, 1'b0);
    ev(5'h10, 8'h02, 4'h0, 32'h1000_0000, 4'h0, 1'b0, 32'h0000_0203);
    ev(5'h10, 8'h02, 4'h0, 32'h1000_0005, 4'h1, 1'b1, 32'h0000_0203);
    access(1'b1, 8'h40, 32'h0000_0000, 1'b0);
    access(1'b1, 8'h41, 32'h0004_0003, 1'b0);
    access(1'b1, 8'h42, 32'h0004_0001, 1'b0);
    ev(5'h10, 8'h02, 4'h0, 32'h1000_0002, 4'h6, 1'b1, 32'h0001_0203);
    ev(5'h01, 8'h07, 4'h0, 32'h0000_0000, 4'h0, 1'b1, 32'h0000_0001);
    ev(5'h02, 8'h04, 4'h0, 32'h0000_0000, 4'h0, 1'b1, 32'h0000_0402);
    ev(5'h04, 8'h03, 4'h6, 32'h0000_0000, 4'h0, 1'b1, 32'h0001_0304);
    ev(5'h08, 8'h01, 4'h8, 32'h0000_0000, 4'h0, 1'b1, 32'h0003_0105);
    ev(5'h05, 8'h06, 4'h1, 32'h0000_0000, 4'h0, 1'b1, 32'h0000_0001);
    $display("test debug entry done");
    osc_run <= 1'b1;
    repeat (30) @(posedge sys_clk);
    osc_run <= 1'b0;
    repeat (6) @(posedge sys_clk);
    for (int i = 0; i < 4; i++) begin
      access(1'b0, 8'h07 + 8'(i), 32'h0000_0000, 1'b0);
      v1[i] = rd_q;
      m1[i] = n_ticks[i];
      check({16'h0, rd_q[15:0]}, {16'h0, m1[i]});
      check(rd_q & 32'hFFFF_0000, 32'h0000_0000);
    end
    osc_run <= 1'b1;
    repeat (40) @(posedge sys_clk);
    osc_run <= 1'b0;
    repeat (6) @(posedge sys_clk);
    for (int i = 0; i < 4; i++) begin
      access(1'b0, 8'h07 + 8'(i), 32'h0000_0000, 1'b0);
      check({16'h0, 16'(rd_q[15:0] - v1[i][15:0])},
            {16'h0, 16'(n_ticks[i] - m1[i])});
      v1[i] = rd_q;
    end
    // new straps must be picked up on the next reset release
    srst <= 1'b1;
    strap <= 4'h2;
    pll_mode_pins <= 2'h1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    for (int i = 0; i < 4; i++) begin
      rd(8'h07 + 8'(i), v1[i], 1'b0);
    end
    rd(8'h41, 32'h0000_0000, 1'b0);
    rd(8'h03, {8'h00, PROC, 16'h0005}, 1'b0);
    $display("test oscillators and reset done");
    final_report();
  end
endmodule : test_debug_status_register_bank
`default_nettype wire
